// >>> rtl/swg_all_setpoints_load_gen.sv
// Set-point store, trip checks, slew limiter and function generator
//
// Contract
// - Combined load commits four set-points in one cycle
// - Voltage set-point held, resets to minimum
// - Sustained under-voltage disconnects and flags fault
// - Sustained over-voltage disconnects and flags fault
// - Falling slew limit bounds decreasing voltage while src_fg is clear
// - Rising slew limit, resets to fastest rate
// - Combined slew: rising first, falling second
// - Requested slew snaps to nearest realisable step
// - Slew below min to slowest, above max fastest
// - Ramp high level used in ramp, default 50
// - Ramp low level programmable, default 10
// - Ramp fall time in ms, 2 to 65000
// - Ramp rise time in ms, 2 to 65000
// - Sine amplitude used in sine, default 10
// - Sine midline offset, default 50
// - Sine period in ms, 2 to 65000
// - Type codes: 0 sine,1 square,2 step,3 ramp
`timescale 1ns/100ps
`include "swg_consts.svh"

module swg_all_setpoints_load_gen #(
  parameter int MS_CYCLES = `SWG_MS_CYCLES,
  parameter int SAMPLE_CYCLES = `SWG_SAMPLE_CYCLES,
  parameter int TRIP_SAMPLES = `SWG_TRIP_SAMPLES
) (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [15:0] meas_v, // measured input voltage, async
  output logic [15:0] vset_out, // voltage regulation target
  output logic [15:0] curr_set, // current set-point
  output logic [15:0] pow_set, // power set-point
  output logic [15:0] res_set, // resistance set-point
  output logic input_connect, // input switch closed
  output logic under_voltage_trip, // under-voltage fault latched
  output logic over_voltage_trip, // over-voltage fault latched
  output logic irq // level interrupt
);
  // ========================================================================
  // Helpers
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  function automatic logic [15:0] slew_fit(input logic [15:0] v);
    logic [16:0] r;
    r = 17'(v) + 17'(`SWG_SLEW_STEP >> 1);
    r = (r / 17'(`SWG_SLEW_STEP)) * 17'(`SWG_SLEW_STEP);
    if (r > 17'(`SWG_SLEW_MAX)) r = 17'(`SWG_SLEW_MAX);
    slew_fit = clamp16(r[15:0], `SWG_SLEW_MIN, `SWG_SLEW_MAX);
  endfunction : slew_fit

  function automatic logic [15:0] interp(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] t, input logic [15:0] d);
    logic [31:0] span;
    span = (32'((b >= a) ? b - a : a - b) * 32'(t)) / 32'(d);
    interp = (b >= a) ? a + span[15:0] : a - span[15:0];
  endfunction : interp

  // Quarter-wave magnitudes, entry k in byte k
  function automatic logic [7:0] sin_q(input logic [3:0] k);
    logic [127:0] tab;
    tab = 128'hFEFAF4ECE1D4C5B4A28E79624A321900;
    sin_q = tab[{k, 3'h0} +: 8];
  endfunction : sin_q

  // ========================================================================
  // Bus decode
  logic bus_req, wr_lo, wr_hi, rd_status, do_defaults;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Partial-lane writes to a 16-bit field are ignored
  assign wr_lo = bus_req & wb_we_i & wb_sel_i[1] & wb_sel_i[0];
  assign wr_hi = bus_req & wb_we_i & wb_sel_i[3] & wb_sel_i[2];
  assign rd_status = bus_req & ~wb_we_i & (wb_adr_i == `SWG_OFS_STATUS);
  assign do_defaults = wr_lo & (wb_adr_i == `SWG_OFS_DEFAULTS);

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr_lo & (wb_adr_i == ofs);
  endfunction : hit

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // ========================================================================
  // Control and configuration
  logic src_fg;
  swg_pkg::swg_ftype_t ftype;
  logic [15:0] stg_curr, stg_volt, stg_pow, stg_res;
  logic [15:0] volt_set;
  logic [15:0] uv_thr, ov_thr;
  logic [15:0] slew_rise, slew_fall;
  logic [15:0] ramp_high, ramp_low, ramp_fall, ramp_rise;
  logic [15:0] sin_ampl, sin_offs, sin_per;
  logic [1:0] irq_mask;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_fg <= 1'b0;
      ftype <= swg_pkg::SWG_FN_SINE;
      irq_mask <= 2'h0;
    end else if (hit(`SWG_OFS_CTRL)) begin
      src_fg <= wb_dat_i[`SWG_CTRL_SRC_BIT];
      ftype <= swg_pkg::swg_ftype_t'(wb_dat_i[`SWG_CTRL_FTYPE_LSB +: 2]);
    end else if (hit(`SWG_OFS_MASK)) begin
      irq_mask <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stg_curr <= `SWG_LEVEL_MIN;
      stg_volt <= `SWG_LEVEL_MIN;
      stg_pow <= `SWG_LEVEL_MIN;
      stg_res <= `SWG_LEVEL_MIN;
    end else begin
      if (hit(`SWG_OFS_STG_CURR)) stg_curr <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_STG_VOLT)) stg_volt <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_STG_POW)) stg_pow <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_STG_RES)) stg_res <= wb_dat_i[15:0];
    end
  end

  // Staged values commit together so the load never sees a mixed set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      curr_set <= `SWG_LEVEL_MIN;
      volt_set <= `SWG_LEVEL_MIN;
      pow_set <= `SWG_LEVEL_MIN;
      res_set <= `SWG_LEVEL_MIN;
    end else if (do_defaults) begin
      curr_set <= `SWG_LEVEL_MIN;
      volt_set <= `SWG_LEVEL_MIN;
      pow_set <= `SWG_LEVEL_MIN;
      res_set <= `SWG_LEVEL_MIN;
    end else if (hit(`SWG_OFS_LOAD_ALL)) begin
      curr_set <= stg_curr;
      volt_set <= stg_volt;
      pow_set <= stg_pow;
      res_set <= stg_res;
    end else begin
      if (hit(`SWG_OFS_CURR)) curr_set <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_VOLT)) volt_set <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_POW)) pow_set <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_RES)) res_set <= wb_dat_i[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_thr <= `SWG_LEVEL_MAX;
      ov_thr <= `SWG_LEVEL_MAX;
    end else if (do_defaults) begin
      uv_thr <= `SWG_LEVEL_MAX;
      ov_thr <= `SWG_LEVEL_MAX;
    end else begin
      if (hit(`SWG_OFS_UV_THR)) uv_thr <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_OV_THR)) ov_thr <= wb_dat_i[15:0];
    end
  end

  // Rising half is the low word, falling half the high word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slew_rise <= `SWG_SLEW_MAX;
      slew_fall <= `SWG_SLEW_MAX;
    end else if (do_defaults) begin
      slew_rise <= `SWG_SLEW_MAX;
      slew_fall <= `SWG_SLEW_MAX;
    end else if (bus_req & wb_we_i & (wb_adr_i == `SWG_OFS_SLEW)) begin
      if (wr_lo) slew_rise <= slew_fit(wb_dat_i[15:0]);
      if (wr_hi) slew_fall <= slew_fit(wb_dat_i[`SWG_SLEW_FALL_LSB +: 16]);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_high <= `SWG_RST_RAMP_HIGH;
      ramp_low <= `SWG_RST_RAMP_LOW;
      ramp_fall <= `SWG_RST_RAMP_TIME;
      ramp_rise <= `SWG_RST_RAMP_TIME;
      sin_ampl <= `SWG_RST_SIN_AMPL;
      sin_offs <= `SWG_RST_SIN_OFFS;
      sin_per <= `SWG_RST_SIN_PER;
    end else if (do_defaults) begin
      ramp_high <= `SWG_RST_RAMP_HIGH;
      ramp_low <= `SWG_RST_RAMP_LOW;
      ramp_fall <= `SWG_RST_RAMP_TIME;
      ramp_rise <= `SWG_RST_RAMP_TIME;
      sin_ampl <= `SWG_RST_SIN_AMPL;
      sin_offs <= `SWG_RST_SIN_OFFS;
      sin_per <= `SWG_RST_SIN_PER;
    end else begin
      if (hit(`SWG_OFS_RAMP_HIGH)) ramp_high <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_RAMP_LOW)) ramp_low <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_RAMP_FALL))
        ramp_fall <= clamp16(wb_dat_i[15:0], `SWG_PER_MIN, `SWG_PER_MAX);
      if (hit(`SWG_OFS_RAMP_RISE))
        ramp_rise <= clamp16(wb_dat_i[15:0], `SWG_PER_MIN, `SWG_PER_MAX);
      if (hit(`SWG_OFS_SIN_AMPL)) sin_ampl <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_SIN_OFFS)) sin_offs <= wb_dat_i[15:0];
      if (hit(`SWG_OFS_SIN_PER))
        sin_per <= clamp16(wb_dat_i[15:0], `SWG_PER_MIN, `SWG_PER_MAX);
    end
  end

  // ========================================================================
  // Ticks and measurement synchroniser
  logic [31:0] ms_cnt, smp_cnt;
  logic ms_tick, smp_tick;
  logic [15:0] meas_m, meas_s;
  assign ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
  assign smp_tick = (smp_cnt == 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= 32'h0000_0000;
      smp_cnt <= 32'h0000_0000;
    end else begin
      ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
      smp_cnt <= smp_tick ? 32'h0000_0000 : smp_cnt + 32'h0000_0001;
    end
  end

  // Converter holds its word steady between samples, so a bus sync is safe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_m <= 16'h0000;
      meas_s <= 16'h0000;
    end else begin
      meas_m <= meas_v;
      meas_s <= meas_m;
    end
  end

  // ========================================================================
  // Trip detection
  logic [7:0] uv_cnt, ov_cnt;
  logic uv_event, ov_event;
  logic reconnect;
  logic [1:0] status;
  assign uv_event = smp_tick & (meas_s < uv_thr) & (uv_cnt == 8'(TRIP_SAMPLES - 1));
  assign ov_event = smp_tick & (meas_s > ov_thr) & (ov_cnt == 8'(TRIP_SAMPLES - 1));
  assign reconnect = do_defaults | (hit(`SWG_OFS_CTRL) & wb_dat_i[`SWG_CTRL_RECONNECT_BIT]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_cnt <= 8'h00;
      ov_cnt <= 8'h00;
    end else if (smp_tick) begin
      if (meas_s >= uv_thr) uv_cnt <= 8'h00;
      else if (uv_cnt != 8'(TRIP_SAMPLES - 1)) uv_cnt <= uv_cnt + 8'h01;
      if (meas_s <= ov_thr) ov_cnt <= 8'h00;
      else if (ov_cnt != 8'(TRIP_SAMPLES - 1)) ov_cnt <= ov_cnt + 8'h01;
    end
  end

  // A trip that lands with the reconnect keeps the input open
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      under_voltage_trip <= 1'b0;
      over_voltage_trip <= 1'b0;
    end else begin
      under_voltage_trip <= uv_event | (under_voltage_trip & ~reconnect);
      over_voltage_trip <= ov_event | (over_voltage_trip & ~reconnect);
    end
  end
  assign input_connect = ~(under_voltage_trip | over_voltage_trip);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 2'h0;
    end else begin
      status <= {ov_event, uv_event} | (status & {2{~rd_status}});
    end
  end
  assign irq = |(status & irq_mask);

  // ========================================================================
  // Function generator
  logic fg_run, is_ramp;
  swg_pkg::swg_seg_t seg;
  logic [15:0] t_ms, dur, ramp_val, sin_val;
  assign is_ramp = (ftype == swg_pkg::SWG_FN_RAMP);
  assign fg_run = src_fg & (is_ramp | (ftype == swg_pkg::SWG_FN_SINE));
  assign dur = !is_ramp ? sin_per : ((seg == swg_pkg::SWG_SEG_RISE) ? ramp_rise : ramp_fall);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seg <= swg_pkg::SWG_SEG_RISE;
      t_ms <= 16'h0000;
    end else if (!fg_run) begin
      seg <= swg_pkg::SWG_SEG_RISE;
      t_ms <= 16'h0000;
    end else if (ms_tick) begin
      if (t_ms + 16'h0001 >= dur) begin
        t_ms <= 16'h0000;
        if (is_ramp) seg <= swg_pkg::swg_seg_t'(~seg);
      end else begin
        t_ms <= t_ms + 16'h0001;
      end
    end
  end

  // Combinational divides; fine at a 1 ms update rate if timing is multicycled
  always_comb begin
    if (seg == swg_pkg::SWG_SEG_RISE) ramp_val = interp(ramp_low, ramp_high, t_ms, ramp_rise);
    else ramp_val = interp(ramp_high, ramp_low, t_ms, ramp_fall);
  end

  always_comb begin
    logic [31:0] ph;
    logic [5:0] idx;
    logic [7:0] mag;
    logic [23:0] term;
    logic [16:0] sum;
    sum = 17'h00000;
    ph = (32'(t_ms) << 6) / 32'(sin_per);
    idx = ph[5:0];
    mag = idx[4] ? sin_q(4'hF - idx[3:0]) : sin_q(idx[3:0]);
    // Scaled by the table peak so the crest reaches the full amplitude
    term = (24'(sin_ampl) * 24'(mag)) / 24'h0000FE;
    if (!idx[5]) begin
      sum = 17'(sin_offs) + 17'(term[15:0]);
      sin_val = sum[16] ? `SWG_LEVEL_MAX : sum[15:0];
    end else begin
      sin_val = (term[15:0] > sin_offs) ? `SWG_LEVEL_MIN : sin_offs - term[15:0];
    end
  end

  // ========================================================================
  // Output target with slew limiting
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vset_out <= `SWG_LEVEL_MIN;
    end else if (src_fg) begin
      // Square and step are not generated here; the output holds
      if (ftype == swg_pkg::SWG_FN_RAMP) vset_out <= ramp_val;
      else if (ftype == swg_pkg::SWG_FN_SINE) vset_out <= sin_val;
    end else if (ms_tick) begin
      if (volt_set > vset_out)
        vset_out <= (volt_set - vset_out > slew_rise) ? vset_out + slew_rise : volt_set;
      else if (volt_set < vset_out)
        vset_out <= (vset_out - volt_set > slew_fall) ? vset_out - slew_fall : volt_set;
    end
  end

  // ========================================================================
  // Read back
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req & ~wb_we_i) begin
      case (wb_adr_i)
        `SWG_OFS_CTRL: wb_dat_o <= {26'h0, ftype, 3'h0, src_fg};
        `SWG_OFS_STG_CURR: wb_dat_o <= {16'h0, stg_curr};
        `SWG_OFS_STG_VOLT: wb_dat_o <= {16'h0, stg_volt};
        `SWG_OFS_STG_POW: wb_dat_o <= {16'h0, stg_pow};
        `SWG_OFS_STG_RES: wb_dat_o <= {16'h0, stg_res};
        `SWG_OFS_CURR: wb_dat_o <= {16'h0, curr_set};
        `SWG_OFS_VOLT: wb_dat_o <= {16'h0, volt_set};
        `SWG_OFS_POW: wb_dat_o <= {16'h0, pow_set};
        `SWG_OFS_RES: wb_dat_o <= {16'h0, res_set};
        `SWG_OFS_UV_THR: wb_dat_o <= {16'h0, uv_thr};
        `SWG_OFS_OV_THR: wb_dat_o <= {16'h0, ov_thr};
        `SWG_OFS_SLEW: wb_dat_o <= {slew_fall, slew_rise};
        `SWG_OFS_RAMP_HIGH: wb_dat_o <= {16'h0, ramp_high};
        `SWG_OFS_RAMP_LOW: wb_dat_o <= {16'h0, ramp_low};
        `SWG_OFS_RAMP_FALL: wb_dat_o <= {16'h0, ramp_fall};
        `SWG_OFS_RAMP_RISE: wb_dat_o <= {16'h0, ramp_rise};
        `SWG_OFS_SIN_AMPL: wb_dat_o <= {16'h0, sin_ampl};
        `SWG_OFS_SIN_OFFS: wb_dat_o <= {16'h0, sin_offs};
        `SWG_OFS_SIN_PER: wb_dat_o <= {16'h0, sin_per};
        `SWG_OFS_STATUS: wb_dat_o <= {30'h0, status};
        `SWG_OFS_MASK: wb_dat_o <= {30'h0, irq_mask};
        `SWG_OFS_OUT: wb_dat_o <= {14'h0, over_voltage_trip, under_voltage_trip, vset_out};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule : swg_all_setpoints_load_gen

// >>> inc/swg_consts.svh
// Offsets, field positions, reset values and timing counts of the set-point generator
`ifndef SWG_CONSTS_SVH
`define SWG_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define SWG_OFS_CTRL 8'h00
`define SWG_OFS_STG_CURR 8'h04
`define SWG_OFS_STG_VOLT 8'h08
`define SWG_OFS_STG_POW 8'h0C
`define SWG_OFS_STG_RES 8'h10
`define SWG_OFS_LOAD_ALL 8'h14
`define SWG_OFS_CURR 8'h18
`define SWG_OFS_VOLT 8'h1C
`define SWG_OFS_POW 8'h20
`define SWG_OFS_RES 8'h24
`define SWG_OFS_UV_THR 8'h28
`define SWG_OFS_OV_THR 8'h2C
`define SWG_OFS_SLEW 8'h30
`define SWG_OFS_RAMP_HIGH 8'h34
`define SWG_OFS_RAMP_LOW 8'h38
`define SWG_OFS_RAMP_FALL 8'h3C
`define SWG_OFS_RAMP_RISE 8'h40
`define SWG_OFS_SIN_AMPL 8'h44
`define SWG_OFS_SIN_OFFS 8'h48
`define SWG_OFS_SIN_PER 8'h4C
`define SWG_OFS_STATUS 8'h50
`define SWG_OFS_MASK 8'h54
`define SWG_OFS_DEFAULTS 8'h58
`define SWG_OFS_OUT 8'h5C

// ==========================================================================
// Field positions
`define SWG_CTRL_SRC_BIT 0
`define SWG_CTRL_FTYPE_LSB 4
`define SWG_CTRL_RECONNECT_BIT 8
`define SWG_ST_UV_BIT 0
`define SWG_ST_OV_BIT 1
`define SWG_SLEW_FALL_LSB 16

// ==========================================================================
// Ranges and reset values
`define SWG_LEVEL_MIN 16'h0000
`define SWG_LEVEL_MAX 16'hFFFF
`define SWG_SLEW_MIN 16'h0001
`define SWG_SLEW_MAX 16'h1000
`define SWG_SLEW_STEP 16'h0004
`define SWG_PER_MIN 16'h0002
`define SWG_PER_MAX 16'hFDE8
`define SWG_RST_RAMP_HIGH 16'h0032
`define SWG_RST_RAMP_LOW 16'h000A
`define SWG_RST_RAMP_TIME 16'h000A
`define SWG_RST_SIN_AMPL 16'h000A
`define SWG_RST_SIN_OFFS 16'h0032
`define SWG_RST_SIN_PER 16'h000A

// ==========================================================================
// Timing
`define SWG_CLK_MHZ 200
`define SWG_MS_US 1000
`define SWG_MS_CYCLES (`SWG_CLK_MHZ * `SWG_MS_US)
`define SWG_SAMPLE_US 10
`define SWG_SAMPLE_CYCLES (`SWG_CLK_MHZ * `SWG_SAMPLE_US)
`define SWG_TRIP_SAMPLES 4

`endif

// >>> inc/swg_pkg.sv
// Types shared by the set-point generator
package swg_pkg;
  // ========================================================================
  // Function type and ramp segment
  typedef enum logic [1:0] {
    SWG_FN_SINE = 2'h0,
    SWG_FN_SQUARE = 2'h1,
    SWG_FN_STEP = 2'h2,
    SWG_FN_RAMP = 2'h3
  } swg_ftype_t;

  typedef enum logic {
    SWG_SEG_RISE = 1'b0,
    SWG_SEG_FALL = 1'b1
  } swg_seg_t;
endpackage : swg_pkg

// >>> tb/swg_checker.sv
// Assertions on the set-point generator's bus and fault ports
`timescale 1ns/100ps
module swg_checker (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // ack
  input wire logic input_connect, // switch
  input wire logic under_voltage_trip, // uv fault
  input wire logic over_voltage_trip // ov fault
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================
  // Bus
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_on_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_needs_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdata_on_read: assert property
    ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i)) else $error("read data moved");
  // ==========================
  // Faults; a latched fault only drops on a register write
  a_uv_disconnects: assert property (under_voltage_trip |-> !input_connect)
    else $error("uv fault with input connected");
  a_ov_disconnects: assert property (over_voltage_trip |-> !input_connect)
    else $error("ov fault with input connected");
  a_uv_fault_latched: assert property
    ($fell(under_voltage_trip) |-> $past(wb_cyc_i && wb_we_i)) else $error("uv fault lost");
  a_ov_fault_latched: assert property
    ($fell(over_voltage_trip) |-> $past(wb_cyc_i && wb_we_i)) else $error("ov fault lost");
  a_disconnect_has_cause: assert property
    (!input_connect |-> under_voltage_trip || over_voltage_trip) else $error("no cause");
endmodule : swg_checker

bind swg_all_setpoints_load_gen swg_checker u_swg_checker (.sys_clk(sys_clk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .input_connect(input_connect),
  .under_voltage_trip(under_voltage_trip), .over_voltage_trip(over_voltage_trip));

// >>> tb/swg_host.sv
// Remote controller model: classic Wishbone master issuing register commands
`timescale 1ns/100ps
module swg_host (
  input wire logic clk, // bus clock
  output logic cyc = 1'b0, // cycle
  output logic stb = 1'b0, // strobe
  output logic we = 1'b0, // write
  output logic [7:0] adr = 8'h00, // address
  output logic [3:0] sel = 4'h0, // lanes
  output logic [31:0] dat_w = 32'h0000_0000, // write data
  input wire logic [31:0] dat_r, // read data
  input wire logic ack // acknowledge
);
  // Request held until ack is seen at an edge; a silent slave ends it after 50 cycles
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic ok);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    ok = 1'b0;
    q = 32'h0000_0000;
    for (int i = 0; i < 50 && !ok; i++) begin
      @(posedge clk);
      if (ack === 1'b1) begin
        ok = 1'b1;
        q = dat_r;
      end
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
endmodule : swg_host

// >>> tb/tb_top.sv
// Scenario bench for the set-point generator
`timescale 1ns/100ps
module tb_top;
  localparam int MS = 20;
  localparam logic [7:0] DA [0:9] = '{8'h1C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48,
    8'h4C, 8'h60};
  localparam logic [31:0] DV [0:9] = '{32'h0, 32'h1000_1000, 32'h32, 32'hA, 32'hA, 32'hA,
    32'hA, 32'h32, 32'hA, 32'h0};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, input_connect;
  logic under_voltage_trip, over_voltage_trip, irq, ok;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] meas_v = 16'h0100;
  logic [15:0] vset_out, curr_set, pow_set, res_set, v;
  int error_cnt = 0;
  int samples_checked = 0;
  always #2.5 sys_clk = ~sys_clk;
  swg_host u_swg_host (.clk(sys_clk), .cyc(wb_cyc_i), .stb(wb_stb_i), .we(wb_we_i),
    .adr(wb_adr_i), .sel(wb_sel_i), .dat_w(wb_dat_i), .dat_r(wb_dat_o), .ack(wb_ack_o));
  // Short ms and sample counts keep the run small
  swg_all_setpoints_load_gen #(.MS_CYCLES(MS), .SAMPLE_CYCLES(4), .TRIP_SAMPLES(4)) u_swg_all_setpoints_load_gen (
    .sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .meas_v, .vset_out, .curr_set, .pow_set, .res_set, .input_connect,
    .under_voltage_trip, .over_voltage_trip, .irq);
  // ==========================
  // Helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    samples_checked++;
    if (got !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_swg_host.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR bus ack expected 1 seen 0");
      print_verdict();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("read data", e, q);
  endtask : rd
  task automatic wait_val(input logic [15:0] e, input int n);
    for (int i = 0; i < n && vset_out !== e; i++) begin
      @(posedge sys_clk);
    end
    chk("vset_out", {16'h0, e}, {16'h0, vset_out});
  endtask : wait_val
  task automatic wait_fault(input logic ov);
    for (int i = 0; i < 100 && {over_voltage_trip, under_voltage_trip} !== {ov, !ov}; i++) begin
      @(posedge sys_clk);
    end
    chk("fault", {30'h0, ov, !ov}, {30'h0, over_voltage_trip, under_voltage_trip});
    chk("connect", 32'h0, {31'h0, input_connect});
  endtask : wait_fault
  // ==========================
  // Scenarios
  task automatic test_slew();
    wr(8'h30, 32'hFFFF_0000);
    rd(8'h30, 32'h1000_0001);
    wr(8'h30, 32'h0013_0009);
    rd(8'h30, 32'h0014_0008);
    wr(8'h30, 32'h0004_0008);
    wr(8'h08, 32'h20);
    wr(8'h14, 32'h1);
    for (int k = 1; k <= 4; k++) begin
      wait_val(16'(8 * k), MS + 5);
    end
    $display("slew test done");
  endtask : test_slew
  task automatic test_load();
    wr(8'h04, 32'h1111);
    wr(8'h08, 32'h0018);
    wr(8'h0C, 32'h3333);
    wr(8'h10, 32'h4444);
    chk("curr_set", 32'h0, {16'h0, curr_set});
    wr(8'h14, 32'h1);
    chk("pow_set", 32'h3333, {16'h0, pow_set});
    chk("res_set", 32'h4444, {16'h0, res_set});
    chk("curr_set", 32'h1111, {16'h0, curr_set});
    rd(8'h18, 32'h1111);
    rd(8'h1C, 32'h0018);
    wait_val(16'h001C, MS + 5);
    wait_val(16'h0018, MS + 5);
    $display("load test done");
  endtask : test_load
  task automatic test_trip();
    wr(8'h54, 32'h3);
    wr(8'h28, 32'h0200);
    wait_fault(1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h28, 32'h0);
    rd(8'h50, 32'h1);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h100);
    chk("connect", 32'h1, {31'h0, input_connect});
    wr(8'h54, 32'h1);
    wr(8'h2C, 32'h0200);
    meas_v <= 16'h0300;
    wait_fault(1'b1);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h50, 32'h2);
    meas_v <= 16'h0100;
    wr(8'h2C, 32'hFFFF);
    wr(8'h00, 32'h100);
    $display("trip test done");
  endtask : test_trip
  task automatic test_fgen();
    wr(8'h34, 32'h30);
    wr(8'h38, 32'h10);
    wr(8'h3C, 32'h1);
    rd(8'h3C, 32'h2);
    wr(8'h40, 32'hFFFF);
    rd(8'h40, 32'hFDE8);
    wr(8'h40, 32'h2);
    wr(8'h00, 32'h31);
    wait_val(16'h0030, 200);
    wait_val(16'h0010, 3 * MS);
    wait_val(16'h0030, 3 * MS);
    wr(8'h44, 32'h10);
    wr(8'h48, 32'h40);
    wr(8'h4C, 32'h40);
    wr(8'h00, 32'h01);
    wait_val(16'h0050, 1400);
    wait_val(16'h0030, 700);
    for (int t = 1; t <= 2; t++) begin
      wr(8'h00, 32'(t * 16 + 1));
      v = vset_out;
      repeat (3 * MS) @(posedge sys_clk);
      chk("held level", {16'h0, v}, {16'h0, vset_out});
    end
    $display("function test done");
  endtask : test_fgen
  task automatic test_defaults();
    wr(8'h34, 32'h1234);
    wr(8'h58, 32'h1);
    for (int i = 0; i < 10; i++) begin
      rd(DA[i], DV[i]);
    end
    $display("defaults test done");
  endtask : test_defaults
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(8'h28, 32'h0);
    test_slew();
    test_load();
    test_trip();
    test_fgen();
    test_defaults();
    print_verdict();
  end
endmodule : tb_top
